// [logic/ulpd_pkg.sv]
package ulpd_pkg;

    // ****************************************
    // register map (byte addresses)
    // ****************************************
    localparam logic [31:0] LPDIV_LOW_ADDR  = 32'h5000_1020;
    localparam logic [31:0] LPDIV_HIGH_ADDR = 32'h5000_1024;
    localparam logic [31:0] LINE_CTRL_ADDR  = 32'h5000_10f0;
    localparam logic [31:0] LP_STATUS_ADDR  = 32'h5000_10f4;

    // ****************************************
    // fields and reset values
    // ****************************************
    localparam int unsigned DIV_ACCESS_POS  = 7;
    localparam int unsigned STAT_RUN_POS    = 0;
    localparam int unsigned STAT_SETTLE_POS = 1;
    localparam int unsigned STAT_CNT_LSB    = 8;
    localparam logic [7:0]  DIV_BYTE_RESET  = 8'h00;
    localparam logic        DIV_ACCESS_RESET = 1'b0;
    localparam logic [31:0] RDATA_RESET     = 32'h0000_0000;

    // ****************************************
    // timing
    // ****************************************
    localparam logic [3:0]  SETTLE_CYCLES   = 4'h8;
    localparam logic [3:0]  OVERSAMPLE_LAST = 4'hf;

    typedef struct packed {
        logic        ack;
        logic [31:0] rdata;
        logic [7:0]  div_lo;
        logic [7:0]  div_hi;
        logic        div_access;
        logic [3:0]  settle;
        logic        sir_prev;
        logic        pulse;
        logic [7:0]  pulse_cnt;
    } ulpd_top_state_t;

    typedef struct packed {
        logic [15:0] cnt;
        logic [3:0]  phase;
        logic        tick16;
        logic        tick;
    } ulpd_gen_state_t;

endpackage : ulpd_pkg

// [logic/ulpd_baud_if.sv]
`timescale 1ns/1ps
`default_nettype none

interface ulpd_baud_if;
    logic [15:0] divisor;
    logic        enable;
    logic        tick16;
    logic        tick;

    modport gen  (input divisor, output enable, output tick16, output tick);
    modport user (output divisor, input enable, input tick16, input tick);
endinterface : ulpd_baud_if

`default_nettype wire

// [logic/ulpd_baud_gen.sv]
`timescale 1ns/1ps
`default_nettype none

module ulpd_baud_gen (
    input  wire logic     clock_i,
    input  wire logic     resetn_i,
    ulpd_baud_if.gen      baud
);
    import ulpd_pkg::*;

    ulpd_gen_state_t s_q;
    ulpd_gen_state_t s_d;

    // zero divisor stops everything
    assign baud.enable = (baud.divisor != 16'h0000);
    assign baud.tick16 = s_q.tick16;
    assign baud.tick   = s_q.tick;

    always_comb begin
        s_d        = s_q;
        s_d.tick16 = 1'b0;
        s_d.tick   = 1'b0;
        if (!baud.enable) begin
            s_d.cnt   = 16'h0000;
            s_d.phase = 4'h0;
        end else if (s_q.cnt >= baud.divisor - 16'h0001) begin
            // >= so a smaller new divisor cannot run the count past it
            s_d.cnt    = 16'h0000;
            s_d.tick16 = 1'b1;
            s_d.phase  = s_q.phase + 4'h1;
            s_d.tick   = (s_q.phase == OVERSAMPLE_LAST);    // sclk/(16*div)
        end else begin
            s_d.cnt = s_q.cnt + 16'h0001;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

endmodule : ulpd_baud_gen

`default_nettype wire

// [logic/ulpd_divisor.sv]
// The Avalon-MM slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none

module ulpd_divisor (
    input  wire logic        clock_i,
    input  wire logic        resetn_i,
    input  wire logic [31:0] avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    input  wire logic        lp_mode_i,
    input  wire logic        sir_in_i,
    output logic      [15:0] lowpower_divisor_o,
    output logic             lp_baud_enable_o,
    output logic             lp_baud16_tick_o,
    output logic             lp_baud_tick_o,
    output logic             divisor_latch_access_bit_o,
    output logic             lp_pulse_detect_o
);
    import ulpd_pkg::*;

    ulpd_top_state_t s_q;
    ulpd_top_state_t s_d;

    ulpd_baud_if baud ();

    ulpd_baud_gen ulpd_baud_gen_i (
        .clock_i  (clock_i),
        .resetn_i (resetn_i),
        .baud     (baud)
    );

    // ****************************************
    // register select
    // ****************************************
    typedef enum {
        SEL_NONE,
        SEL_LOW,
        SEL_HIGH,
        SEL_LINE,
        SEL_STAT
    } ulpd_sel_t;

    ulpd_sel_t sel;

    // full decode: any other address is a hole that reads zero
    always_comb begin
        unique case (avs_address_i)
            LPDIV_LOW_ADDR: begin
                sel = SEL_LOW;
            end
            LPDIV_HIGH_ADDR: begin
                sel = SEL_HIGH;
            end
            LINE_CTRL_ADDR: begin
                sel = SEL_LINE;
            end
            LP_STATUS_ADDR: begin
                sel = SEL_STAT;
            end
            default: begin
                sel = SEL_NONE;
            end
        endcase
    end

    // ****************************************
    // bus handshake
    // ****************************************
    logic req;
    logic first_cycle;
    logic wr_take;
    logic wr_byte0;
    logic div_open;

    assign req               = avs_read_i | avs_write_i;
    // one wait cycle: read data is registered in the first, handed over in the second
    assign first_cycle       = req & ~s_q.ack;
    assign avs_waitrequest_o = first_cycle;
    // writes land only on the edge where waitrequest is low
    assign wr_take           = avs_write_i & s_q.ack;
    // upper byte lanes carry only reserved bits, so lane 0 gates the write
    assign wr_byte0          = wr_take & avs_byteenable_i[0];
    assign div_open          = s_q.div_access;

    // ****************************************
    // write strobes
    // ****************************************
    logic wr_low;
    logic wr_high;
    logic wr_line;
    logic wr_div;

    // a locked divisor register swallows the write
    assign wr_low  = wr_byte0 & (sel == SEL_LOW) & div_open;
    assign wr_high = wr_byte0 & (sel == SEL_HIGH) & div_open;
    assign wr_line = wr_byte0 & (sel == SEL_LINE);
    assign wr_div  = wr_low | wr_high;

    // ****************************************
    // status word
    // ****************************************
    logic        settled;
    logic [31:0] stat_word;

    // advisory only: nothing is held off while the settle count runs
    assign settled = (s_q.settle == 4'h0);

    always_comb begin
        stat_word                    = RDATA_RESET;
        stat_word[STAT_RUN_POS]      = baud.enable;
        stat_word[STAT_SETTLE_POS]   = settled;
        stat_word[STAT_CNT_LSB +: 8] = s_q.pulse_cnt;
    end

    // ****************************************
    // read mux
    // ****************************************
    logic [31:0] rd_mux;

    // bits 31:8 of the divisor registers stay zero
    always_comb begin
        rd_mux = RDATA_RESET;
        unique case (sel)
            SEL_LOW: begin
                if (div_open) begin
                    rd_mux[7:0] = s_q.div_lo;
                end
            end
            SEL_HIGH: begin
                if (div_open) begin
                    rd_mux[7:0] = s_q.div_hi;
                end
            end
            SEL_LINE: begin
                rd_mux[DIV_ACCESS_POS] = s_q.div_access;
            end
            SEL_STAT: begin
                rd_mux = stat_word;
            end
            SEL_NONE: begin
                rd_mux = RDATA_RESET;
            end
        endcase
    end

    // ****************************************
    // pulse detect
    // ****************************************
    logic sample;
    logic sir_rise;
    logic pulse_hit;

    // the input is looked at only on the 16x low-power tick, so a pulse
    // shorter than one tick period may be missed
    assign sample    = baud.enable & baud.tick16;
    assign sir_rise  = sir_in_i & ~s_q.sir_prev;
    assign pulse_hit = sample & sir_rise & lp_mode_i;

    // ****************************************
    // state update
    // ****************************************
    always_comb begin
        s_d       = s_q;
        s_d.ack   = first_cycle;
        s_d.pulse = 1'b0;

        // read data is frozen in the first cycle and stands until the next request
        if (first_cycle) begin
            s_d.rdata = avs_read_i ? rd_mux : RDATA_RESET;
        end

        if (!settled) begin
            s_d.settle = s_q.settle - 4'h1;
        end

        if (wr_low) begin
            s_d.div_lo = avs_writedata_i[7:0];
        end
        if (wr_high) begin
            s_d.div_hi = avs_writedata_i[7:0];
        end
        if (wr_div) begin
            s_d.settle = SETTLE_CYCLES;
        end
        if (wr_line) begin
            s_d.div_access = avs_writedata_i[DIV_ACCESS_POS];
        end

        // a zero divisor clears the edge history, so an input already high fires an edge at the first 16x tick after restart
        if (!baud.enable) begin
            s_d.sir_prev = 1'b0;
        end else if (baud.tick16) begin
            s_d.sir_prev = sir_in_i;
        end
        if (pulse_hit) begin
            s_d.pulse     = 1'b1;
            s_d.pulse_cnt = s_q.pulse_cnt + 8'h01;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            s_q            <= '0;
            s_q.div_lo     <= DIV_BYTE_RESET;
            s_q.div_hi     <= DIV_BYTE_RESET;
            s_q.div_access <= DIV_ACCESS_RESET;
            s_q.rdata      <= RDATA_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign baud.divisor               = {s_q.div_hi, s_q.div_lo};
    assign avs_readdata_o             = s_q.rdata;
    assign lowpower_divisor_o         = {s_q.div_hi, s_q.div_lo};
    assign lp_baud_enable_o           = baud.enable;
    assign lp_baud16_tick_o           = baud.tick16;
    assign lp_baud_tick_o             = baud.tick;
    assign divisor_latch_access_bit_o = s_q.div_access;
    assign lp_pulse_detect_o          = s_q.pulse;

endmodule : ulpd_divisor

`default_nettype wire

// [testbench/ulpd_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module ulpd_monitor
    import ulpd_pkg::*;
(
    input wire logic        clock_i,
    input wire logic        resetn_i,
    input wire logic [31:0] avs_address_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0]  avs_byteenable_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic        avs_waitrequest_o,
    input wire logic        lp_mode_i,
    input wire logic        sir_in_i,
    input wire logic [15:0] lowpower_divisor_o,
    input wire logic        lp_baud_enable_o,
    input wire logic        lp_baud16_tick_o,
    input wire logic        lp_baud_tick_o,
    input wire logic        divisor_latch_access_bit_o,
    input wire logic        lp_pulse_detect_o
);
    // ****************************************
    // tick spacing helper
    // ****************************************
    logic [15:0] gap_q;
    logic [15:0] prev_q;
    logic        chg_q;
    wire logic   chg_now = lowpower_divisor_o != prev_q;
    wire logic   done = !avs_waitrequest_o;
    // a divisor change spoils the measured gap, so skip that period
    always_ff @(posedge clock_i) begin
        prev_q <= lowpower_divisor_o;
        gap_q  <= lp_baud16_tick_o ? 16'h0 : gap_q + 16'h1;
        chg_q  <= !resetn_i || chg_now || (chg_q && !lp_baud16_tick_o);
    end
    default clocking @(posedge clock_i); endclocking
    default disable iff (!resetn_i);
    one_wait_a: assert property ($rose(avs_read_i || avs_write_i) |->
        avs_waitrequest_o ##1 !avs_waitrequest_o) else $error("wait state wrong");
    en_zero_a: assert property (lp_baud_enable_o == (lowpower_divisor_o != 16'h0))
        else $error("enable not divisor nonzero");
    off_quiet_a: assert property (!lp_baud_enable_o ##1 !lp_baud_enable_o |->
        !lp_baud16_tick_o && !lp_baud_tick_o && !lp_pulse_detect_o) else $error("tick while off");
    tick_gap_a: assert property (lp_baud16_tick_o && !chg_q && !chg_now |->
        gap_q == lowpower_divisor_o - 16'h1) else $error("tick16 spacing wrong");
    tick_align_a: assert property (lp_baud_tick_o |-> lp_baud16_tick_o)
        else $error("baud tick off grid");
    lock_out_a: assert property (avs_write_i && done && !divisor_latch_access_bit_o |=>
        $stable(lowpower_divisor_o)) else $error("divisor written while locked");
    low_wr_a: assert property (avs_write_i && done && divisor_latch_access_bit_o &&
        avs_byteenable_i[0] && avs_address_i == LPDIV_LOW_ADDR |=>
        lowpower_divisor_o == {$past(lowpower_divisor_o[15:8]), $past(avs_writedata_i[7:0])})
        else $error("low byte write wrong");
    high_wr_a: assert property (avs_write_i && done && divisor_latch_access_bit_o &&
        avs_byteenable_i[0] && avs_address_i == LPDIV_HIGH_ADDR |=>
        lowpower_divisor_o == {$past(avs_writedata_i[7:0]), $past(lowpower_divisor_o[7:0])})
        else $error("high byte write wrong");
    low_rd_a: assert property (avs_read_i && done && avs_address_i == LPDIV_LOW_ADDR |->
        avs_readdata_o == (divisor_latch_access_bit_o ? {24'h0, lowpower_divisor_o[7:0]} : 32'h0))
        else $error("low byte read wrong");
    high_rd_a: assert property (avs_read_i && done && avs_address_i == LPDIV_HIGH_ADDR |->
        avs_readdata_o == (divisor_latch_access_bit_o ? {24'h0, lowpower_divisor_o[15:8]} : 32'h0))
        else $error("high byte read wrong");
    pulse_src_a: assert property (lp_pulse_detect_o |->
        $past(lp_baud16_tick_o && lp_baud_enable_o && lp_mode_i && sir_in_i))
        else $error("pulse without tick");
endmodule : ulpd_monitor
bind ulpd_divisor ulpd_monitor ulpd_monitor_i (.clock_i(clock_i), .resetn_i(resetn_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .lp_mode_i(lp_mode_i), .sir_in_i(sir_in_i), .lowpower_divisor_o(lowpower_divisor_o),
    .lp_baud_enable_o(lp_baud_enable_o), .lp_baud16_tick_o(lp_baud16_tick_o),
    .lp_baud_tick_o(lp_baud_tick_o), .divisor_latch_access_bit_o(divisor_latch_access_bit_o),
    .lp_pulse_detect_o(lp_pulse_detect_o));
`default_nettype wire

// [testbench/uart_low_power_ir_baud_divisor_test.sv]
`timescale 1ns/1ps
`default_nettype none
module uart_low_power_ir_baud_divisor_test;
    import ulpd_pkg::*;
    logic        clock_i, resetn_i, avs_read_i, avs_write_i, lp_mode_i, sir_in_i;
    logic        avs_waitrequest_o, lp_baud_enable_o, lp_baud16_tick_o, lp_baud_tick_o;
    logic        divisor_latch_access_bit_o, lp_pulse_detect_o;
    logic [31:0] avs_address_i, avs_writedata_i, avs_readdata_o, q;
    logic [15:0] lowpower_divisor_o;
    logic [3:0]  avs_byteenable_i;
    int          error_cnt, checks, a, b, c;
    // nearest divisor to 115.2K at the 10 MHz bench clock
    localparam int CLK_HZ  = 10_000_000;
    localparam int LP_BAUD = 115_200;
    localparam int LP_DIV  = (CLK_HZ + 8 * LP_BAUD) / (16 * LP_BAUD);
    ulpd_divisor ulpd_divisor_i (.clock_i(clock_i), .resetn_i(resetn_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .lp_mode_i(lp_mode_i), .sir_in_i(sir_in_i), .lowpower_divisor_o(lowpower_divisor_o),
        .lp_baud_enable_o(lp_baud_enable_o), .lp_baud16_tick_o(lp_baud16_tick_o),
        .lp_baud_tick_o(lp_baud_tick_o), .divisor_latch_access_bit_o(divisor_latch_access_bit_o),
        .lp_pulse_detect_o(lp_pulse_detect_o));
    // ****************************************
    // tasks
    // ****************************************
    task automatic close_out;
        if (error_cnt == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : close_out
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    // values read right after the edge are the ones sampled at it
    task automatic bus(input logic w, input logic [31:0] ad, input logic [31:0] d);
        int k;
        avs_address_i   <= ad;
        avs_writedata_i <= d;
        avs_write_i     <= w;
        avs_read_i      <= !w;
        for (k = 0; k < 20; k++) begin
            @(posedge clock_i);
            if (avs_waitrequest_o === 1'b0) break;
        end
        if (k == 20) begin
            error_cnt++;
            close_out();
        end
        q = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i  <= 1'b0;
        @(posedge clock_i);
    endtask : bus
    // sir goes high for 8 of every 16 cycles
    task automatic run(input int n);
        a = 0;
        b = 0;
        c = 0;
        for (int k = 0; k < n; k++) begin
            @(posedge clock_i);
            a += int'(lp_baud16_tick_o === 1'b1);
            b += int'(lp_baud_tick_o === 1'b1);
            c += int'(lp_pulse_detect_o === 1'b1);
            sir_in_i <= k[3];
        end
    endtask : run
    task automatic scen_regs;
        bus(1'b1, LPDIV_LOW_ADDR, 32'h55);
        bus(1'b0, LPDIV_LOW_ADDR, 32'h0);
        chk("locked_low", q, 32'h0);
        bus(1'b1, LINE_CTRL_ADDR, 32'h80);
        bus(1'b0, LPDIV_LOW_ADDR, 32'h0);
        chk("low_reset", q, 32'h0);
        bus(1'b0, LPDIV_HIGH_ADDR, 32'h0);
        chk("high_reset", q, 32'h0);
        bus(1'b1, LPDIV_LOW_ADDR, 32'hffff_ffa5);
        bus(1'b1, LPDIV_HIGH_ADDR, 32'h0000_013c);
        bus(1'b0, LPDIV_LOW_ADDR, 32'h0);
        chk("low_rd", q, 32'ha5);
        bus(1'b0, LPDIV_HIGH_ADDR, 32'h0);
        chk("high_rd", q, 32'h3c);
        chk("divisor", {16'h0, lowpower_divisor_o}, 32'h3ca5);
        bus(1'b0, LINE_CTRL_ADDR, 32'h0);
        chk("access_bit", q, 32'h80);
        bus(1'b1, LINE_CTRL_ADDR, 32'h0);
        bus(1'b0, LPDIV_HIGH_ADDR, 32'h0);
        chk("locked_high", q, 32'h0);
        bus(1'b1, LPDIV_HIGH_ADDR, 32'h0);
        chk("locked_wr", {16'h0, lowpower_divisor_o}, 32'h3ca5);
        bus(1'b1, LINE_CTRL_ADDR, 32'h80);
    endtask : scen_regs
    task automatic scen_baud;
        bus(1'b1, LPDIV_HIGH_ADDR, 32'h0);
        bus(1'b1, LPDIV_LOW_ADDR, 32'h2);
        bus(1'b0, LP_STATUS_ADDR, 32'h0);
        chk("unsettled", q, 32'h1);
        repeat (8) @(posedge clock_i);
        bus(1'b0, LP_STATUS_ADDR, 32'h0);
        chk("settled", q, 32'h3);
        run(320);
        chk("tick16_cnt", 32'(a), 32'd160);
        chk("tick_cnt", 32'(b), 32'd10);
        chk("pulse_cnt", 32'(c), 32'd20);
        bus(1'b0, LP_STATUS_ADDR, 32'h0);
        chk("pulse_stat", q, 32'h1403);
        bus(1'b1, LPDIV_LOW_ADDR, LP_DIV);
        repeat (8) @(posedge clock_i);
        run(16 * LP_DIV * 10);
        chk("lp_tick16_cnt", 32'(a), 32'(16 * 10));
        chk("lp_tick_cnt", 32'(b), 32'd10);
        chk("lp_pulse_cnt", 32'(c), 32'(LP_DIV * 10));
        bus(1'b1, LPDIV_LOW_ADDR, 32'h0);
        chk("enable_off", {31'h0, lp_baud_enable_o}, 32'h0);
        run(64);
        chk("off_ticks", 32'(a + b + c), 32'h0);
    endtask : scen_baud
    initial begin
        clock_i = 1'b0;
        forever #50 clock_i = ~clock_i;
    end
    initial begin
        {resetn_i, avs_read_i, avs_write_i, sir_in_i} = 4'h0;
        {avs_address_i, avs_writedata_i} = 64'h0;
        avs_byteenable_i = 4'hf;
        lp_mode_i = 1'b1;
        repeat (16) @(posedge clock_i);
        resetn_i <= 1'b1;
        @(posedge clock_i);
        scen_regs();
        scen_baud();
        close_out();
    end
endmodule : uart_low_power_ir_baud_divisor_test
`default_nettype wire
